//--- common/potis_defs.svh
`ifndef POTIS_DEFS_SVH
`define POTIS_DEFS_SVH
// slave address, one ordering option
`define POTIS_SLAVE_ADDR      7'h2f
// command codes
`define POTIS_CMD_NOP         3'h0
`define POTIS_CMD_STORE       3'h1
`define POTIS_CMD_WR_WIPER    3'h2
`define POTIS_CMD_SHUTDOWN    3'h3
`define POTIS_CMD_RELOAD      3'h4
`define POTIS_CMD_RD_WIPER    3'h5
`define POTIS_CMD_READBACK    3'h6
// readback selector in data bits for the read-back command
`define POTIS_SEL_WIPER       8'h00
`define POTIS_SEL_NVM         8'h01
`define POTIS_SEL_TOL         8'h02
// word field positions
`define POTIS_CMD_HI          10
`define POTIS_CMD_LO          8
// reset values
`define POTIS_WIPER_RST       8'h00
// timing
`define POTIS_CLK_HZ          50000000
`define POTIS_STORE_MS        18
`define POTIS_RELOAD_US       25
`define POTIS_STORE_CYC       ((`POTIS_CLK_HZ / 1000) * `POTIS_STORE_MS)
`define POTIS_RELOAD_CYC      ((`POTIS_CLK_HZ / 1000000) * `POTIS_RELOAD_US)
`endif

//--- common/potis_pkg.sv
package potis_pkg;
  typedef enum logic [2:0] {
    POTIS_IDLE = 3'b000,
    POTIS_ADDR = 3'b001,
    POTIS_WRB  = 3'b011,
    POTIS_RDB  = 3'b010,
    POTIS_IGN  = 3'b110
  } potis_phase_t;
  typedef enum logic [1:0] {
    POTIS_RUN   = 2'b00,
    POTIS_STORE = 2'b01,
    POTIS_LOAD  = 2'b11
  } potis_ctl_t;
  typedef enum logic [1:0] {
    POTIS_RES_64  = 2'b00,
    POTIS_RES_32  = 2'b01,
    POTIS_RES_128 = 2'b10
  } potis_res_t;
endpackage

//--- dv/potis_master.sv
`timescale 1ns/1ps
`default_nettype none
module potis_master (
  // clock and bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  logic [8:0] rx_word;
  event       rx_evt;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_word = 9'h000;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // scl low 6 cycles, high 2: slave answers well inside the low phase
  task automatic bit_c(input logic b, output logic v);
    tick(1);
    sda_low = ~b;
    tick(5);
    scl = 1'b1;
    tick(1);
    v = sda;
    tick(1);
    scl = 1'b0;
  endtask
  task automatic start_c;
    tick(1);
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop_c;
    tick(1);
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // ab is the ninth bit sent: 1 releases sda, 0 acknowledges
  task automatic xbyte(input logic [7:0] b, input logic ab);
    logic [8:0] w;
    for (int i = 8; i >= 0; i--) begin
      bit_c(i != 0 ? b[i-1] : ab, w[i]);
    end
    rx_word = w;
    ->rx_evt;
  endtask
endmodule // potis_master
`default_nettype wire

//--- dv/potis_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
module potis_slave_chk
  import potis_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // straps and stored values
  input wire potis_res_t resolution,
  input wire logic [7:0] nvm_init,
  input wire logic [7:0] tol_code,
  // serial pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // analog control
  input wire logic [7:0] wiper_tap,
  input wire logic       shutdown,
  input wire logic [7:0] nvm_value,
  input wire logic       nvm_busy
);
  logic [3:0] rst_age;
  logic [7:0] keep;
  assign keep = (resolution == POTIS_RES_32) ? 8'hfc : (resolution == POTIS_RES_64) ? 8'hfe : 8'hff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // the stored value settles a few cycles after reset, not only on a store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_age <= 4'h0;
    end else if (rst_age != 4'hf) begin
      rst_age <= rst_age + 4'h1;
    end
  end
  sequence s_loaded;
    ##[1:3] wiper_tap == (nvm_init & keep);
  endsequence
  sequence s_busy_run;
    nvm_busy [*8];
  endsequence
  AST_SDA_OUT: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  AST_OE_SCL: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda moved while scl high");
  AST_WIPER_MASK: assert property ((wiper_tap & ~keep) == 8'h00)
    else $error("ignored wiper bits set");
  AST_WIPER_LOAD: assert property ($fell(sys_rst) |-> s_loaded)
    else $error("wiper not loaded after reset");
  AST_BUSY_NO_ACK: assert property ($rose(sda_oe) |-> !$past(nvm_busy))
    else $error("ack during store");
  AST_BUSY_HOLD: assert property ($rose(nvm_busy) |=> s_busy_run)
    else $error("store too short");
  AST_NVM_TRACK: assert property ($changed(nvm_value) |-> nvm_busy || $past(nvm_busy) || rst_age < 4'h8)
    else $error("stored value changed outside store");
  AST_SHUT_SCL: assert property ($changed(shutdown) |-> !scl_in)
    else $error("shutdown moved while scl high");
endmodule // potis_slave_chk
bind potis_slave potis_slave_chk i_potis_slave_chk (.clk, .sys_rst, .resolution, .nvm_init,
  .tol_code, .scl_in, .sda_in, .sda_out, .sda_oe, .wiper_tap, .shutdown, .nvm_value, .nvm_busy);
`default_nettype wire

//--- dv/potis_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "potis_defs.svh"
module potis_slave_tb
  import potis_pkg::*;
;
  localparam logic [6:0] own_addr = `POTIS_SLAVE_ADDR;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  nvm_init;
  logic [7:0]  tol_code;
  logic        scl;
  logic        sda;
  logic        m_low;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  wiper_tap;
  logic        shutdown;
  logic [7:0]  nvm_value;
  logic        nvm_busy;
  logic [7:0]  d;
  logic [8:0]  exp_q[$];
  logic [6:0]  bad_addr[3] = '{7'h2e, 7'h00, 7'h78};
  logic [16:0] seed = 17'h11236;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // pulled up: high unless a party pulls it low
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  potis_slave i_potis_slave (.clk, .sys_rst, .resolution(POTIS_RES_64), .nvm_init, .tol_code,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .wiper_tap, .shutdown, .nvm_value, .nvm_busy);
  potis_master i_potis_master (.clk, .sda, .scl, .sda_low(m_low));
  function automatic logic [7:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return seed[7:0];
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic xb(input logic [7:0] b, input logic ab, input logic [8:0] exp);
    exp_q.push_back(exp);
    i_potis_master.xbyte(b, ab);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] v);
    i_potis_master.start_c();
    xb({own_addr, 1'b0}, 1'b1, {own_addr, 2'b00});
    xb({5'h00, c}, 1'b1, {5'h00, c, 1'b0});
    xb(v, 1'b1, {v, 1'b0});
    i_potis_master.stop_c();
  endtask
  task automatic rd(input logic [7:0] v);
    i_potis_master.start_c();
    xb({own_addr, 1'b1}, 1'b1, {own_addr, 2'b10});
    xb(8'hff, 1'b0, 9'h000);
    xb(8'hff, 1'b1, {v, 1'b1});
    i_potis_master.stop_c();
  endtask
  task automatic poll(input logic nack);
    i_potis_master.start_c();
    xb({own_addr, 1'b0}, 1'b1, {own_addr, 1'b0, nack});
    i_potis_master.stop_c();
  endtask
  always @(i_potis_master.rx_evt) begin
    check(i_potis_master.rx_word, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    sys_rst = 1'b1;
    // low bits clear so readback of the stored value does not hinge on masking
    nvm_init = rnd() & 8'hfc;
    tol_code = rnd();
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    check({1'b0, wiper_tap}, {1'b0, nvm_init});
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      cmd(`POTIS_CMD_WR_WIPER, d);
      check({1'b0, wiper_tap}, {1'b0, d & 8'hfe});
      cmd(`POTIS_CMD_RD_WIPER, 8'h00);
      rd(d & 8'hfe);
    end
    cmd(`POTIS_CMD_READBACK, `POTIS_SEL_NVM);
    rd(nvm_init);
    cmd(`POTIS_CMD_READBACK, `POTIS_SEL_TOL);
    rd(tol_code);
    cmd(`POTIS_CMD_READBACK, `POTIS_SEL_WIPER);
    i_potis_master.start_c();
    xb({own_addr, 1'b1}, 1'b1, {own_addr, 2'b10});
    xb(8'hff, 1'b1, 9'h001);
    xb(8'hff, 1'b1, 9'h1ff);
    i_potis_master.stop_c();
    foreach (bad_addr[i]) begin
      i_potis_master.start_c();
      xb({bad_addr[i], 1'b0}, 1'b1, {bad_addr[i], 2'b01});
      xb(8'h55, 1'b1, 9'h0ab);
      i_potis_master.stop_c();
    end
    cmd(`POTIS_CMD_SHUTDOWN, 8'h01);
    check({8'h00, shutdown}, 9'h001);
    cmd(`POTIS_CMD_SHUTDOWN, 8'h00);
    check({8'h00, shutdown}, 9'h000);
    cmd(`POTIS_CMD_WR_WIPER, ~nvm_init);
    cmd(`POTIS_CMD_RELOAD, 8'h00);
    poll(1'b1);
    repeat (1300) @(negedge clk);
    check({1'b0, wiper_tap}, {1'b0, nvm_init});
    poll(1'b0);
    d = rnd();
    cmd(`POTIS_CMD_WR_WIPER, d);
    cmd(`POTIS_CMD_STORE, 8'h00);
    check({8'h00, nvm_busy}, 9'h001);
    check({1'b0, nvm_value}, {1'b0, d & 8'hfe});
    poll(1'b1);
    complete_run();
  end
endmodule // potis_slave_tb
`default_nettype wire

//--- rtl/potis_slave.sv
// Behaviour
// - wiper tap output follows the wiper setting register, unlimited updates.
// - master can write and read back the wiper setting register.
// - during the nonvolatile store no command is acknowledged or executed; words sent after the store in the same write still are.
// - after reset the wiper register loads from nonvolatile memory.
// - command 1 copies the wiper register into nonvolatile memory.
// - command 6 makes the stored nonvolatile value readable.
// - a factory tolerance value is held and readable.
// - slave works at standard and fast mode rates, master stays within; the testbench master clocks scl at one eighth of clk.
// - no ten bit or general call addressing, only seven bit.
// - address byte with direction bit, matching slave acknowledges on ninth clock.
// - direction one reads from the device, zero writes to it.
// - nine clocks per byte, data changes only while clock is low.
// - slave answers one fixed seven bit address, option 0101111.
// - word is five unused bits, three command bits, eight data bits.
// - word is shifted most significant bit first, bit 15 first.
// - 64 positions ignore data lsb, 32 positions ignore two lowest bits.
// - command bits select the operation, data bits load the decoded register.
// - command 4 reloads wiper from nonvolatile memory in about 25 us.
// - command 3 enters shutdown, with data lsb zero leaves it.
// - after a store, acknowledge of the address shows the store is over.
// - on not-acknowledge of the first read byte, the second is not sent.
`timescale 1ns/1ps
`default_nettype none
`include "potis_defs.svh"
module potis_slave
  import potis_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // variant strap
  input  wire potis_res_t resolution,
  // nonvolatile memory contents seen at power-up
  input  wire logic [7:0] nvm_init,
  input  wire logic [7:0] tol_code,
  // serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // analog control
  output logic [7:0]      wiper_tap,
  output logic            shutdown,
  output logic [7:0]      nvm_value,
  output logic            nvm_busy
);
  typedef struct packed {
    potis_phase_t phase;
    potis_ctl_t   ctl;
    logic         scl_d;
    logic         sda_d;
    logic [3:0]   bit_cnt;
    logic [7:0]   shreg;
    logic         byte_sel;
    logic [7:0]   hi_byte;
    logic [15:0]  tx_word;
    logic         drive_low;
    logic         tx_bit;
    logic         read_ack;
    logic         init_done;
    logic [7:0]   wiper_setting_register;
    logic [7:0]   nvm;
    logic [7:0]   rd_sel;
    logic         shut;
    logic         tmr_start;
    logic [19:0]  tmr_count;
  } potis_st_t;

  potis_st_t r;
  potis_st_t next_r;
  logic      scl_s;
  logic      sda_s;
  logic      tmr_busy;
  logic      tmr_done;

  // byte pins pass two flops before anything looks at them
  potis_sync u_scl (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (scl_in),
    .pin_sync (scl_s)
  );
  potis_sync u_sda (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (sda_in),
    .pin_sync (sda_s)
  );
  potis_timer u_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (r.tmr_start),
    .count   (r.tmr_count),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  function automatic logic [7:0] potis_mask(input potis_res_t res, input logic [7:0] d);
    case (res)
      POTIS_RES_64:  potis_mask = {d[7:1], 1'b0};
      POTIS_RES_32:  potis_mask = {d[7:2], 2'b00};
      default:       potis_mask = d;
    endcase
  endfunction

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] byte_in;
  logic [2:0] cmd;

  always_comb begin
    scl_rise   = scl_s & ~r.scl_d;
    scl_fall   = ~scl_s & r.scl_d;
    start_seen = scl_s & r.scl_d & r.sda_d & ~sda_s;
    stop_seen  = scl_s & r.scl_d & ~r.sda_d & sda_s;
    byte_in    = {r.shreg[6:0], sda_s};
    cmd        = r.hi_byte[2:0];
  end

  always_comb begin
    next_r           = r;
    next_r.scl_d     = scl_s;
    next_r.sda_d     = sda_s;
    next_r.tmr_start = 1'b0;
    // power-up restore happens once, one cycle after reset release
    if (!r.init_done) begin
      next_r.init_done              = 1'b1;
      next_r.nvm                    = nvm_init;
      next_r.wiper_setting_register = potis_mask(resolution, nvm_init);
    end
    if (tmr_done) begin
      if (r.ctl == POTIS_LOAD) begin
        next_r.wiper_setting_register = potis_mask(resolution, r.nvm);
      end
      next_r.ctl = POTIS_RUN;
    end
    if (start_seen) begin
      next_r.phase     = POTIS_ADDR;
      next_r.bit_cnt   = 4'h0;
      next_r.drive_low = 1'b0;
      next_r.tx_bit    = 1'b1;
    end else if (stop_seen) begin
      next_r.phase     = POTIS_IDLE;
      next_r.drive_low = 1'b0;
      next_r.tx_bit    = 1'b1;
    end else if (scl_rise && r.phase != POTIS_IDLE && r.phase != POTIS_IGN) begin
      if (r.bit_cnt < 4'h8) begin
        next_r.shreg   = byte_in;
        next_r.bit_cnt = r.bit_cnt + 4'h1;
      end else begin
        // ninth clock high: sample master acknowledge on reads
        next_r.read_ack = ~sda_s;
        next_r.bit_cnt  = 4'h9;
      end
    end else if (scl_fall && r.phase != POTIS_IDLE && r.phase != POTIS_IGN) begin
      next_r.drive_low = 1'b0;
      next_r.tx_bit    = 1'b1;
      if (r.bit_cnt == 4'h8) begin
        // eighth bit in, decide acknowledge for the ninth clock
        case (r.phase)
          POTIS_ADDR: begin
            // any other address, including general call, is ignored
            if (r.shreg[7:1] == `POTIS_SLAVE_ADDR && r.ctl == POTIS_RUN) begin
              next_r.drive_low = 1'b1;
              next_r.byte_sel  = 1'b0;
            end else begin
              next_r.phase = POTIS_IGN;
            end
          end
          POTIS_WRB: begin
            next_r.drive_low = 1'b1;
            if (!r.byte_sel) begin
              next_r.hi_byte  = r.shreg;
              next_r.byte_sel = 1'b1;
            end else begin
              next_r.byte_sel = 1'b0;
              case (cmd)
                `POTIS_CMD_STORE: begin
                  next_r.nvm       = r.wiper_setting_register;
                  next_r.ctl       = POTIS_STORE;
                  next_r.tmr_start = 1'b1;
                  next_r.tmr_count = 20'(`POTIS_STORE_CYC);
                end
                `POTIS_CMD_WR_WIPER: begin
                  next_r.wiper_setting_register = potis_mask(resolution, r.shreg);
                end
                `POTIS_CMD_SHUTDOWN: begin
                  next_r.shut = r.shreg[0];
                end
                `POTIS_CMD_RELOAD: begin
                  next_r.ctl       = POTIS_LOAD;
                  next_r.tmr_start = 1'b1;
                  next_r.tmr_count = 20'(`POTIS_RELOAD_CYC);
                end
                `POTIS_CMD_RD_WIPER: begin
                  next_r.rd_sel = `POTIS_SEL_WIPER;
                end
                `POTIS_CMD_READBACK: begin
                  next_r.rd_sel = r.shreg;
                end
                default: begin
                  next_r.rd_sel = r.rd_sel;
                end
              endcase
            end
          end
          default: begin
            next_r.drive_low = 1'b0;
          end
        endcase
      end else if (r.bit_cnt == 4'h9) begin
        // ninth clock over, begin next byte
        next_r.bit_cnt = 4'h0;
        if (r.phase == POTIS_ADDR) begin
          if (r.shreg[0]) begin
            next_r.phase   = POTIS_RDB;
            // the tolerance code is no wiper value, so none of its bits are dropped
            next_r.tx_word = {8'h00, r.rd_sel == `POTIS_SEL_TOL ? tol_code :
                             potis_mask(resolution, r.rd_sel == `POTIS_SEL_NVM ? r.nvm :
                             r.wiper_setting_register)};
            next_r.tx_bit  = 1'b0;
          end else begin
            next_r.phase = POTIS_WRB;
          end
        end else if (r.phase == POTIS_RDB) begin
          if (r.read_ack && !r.byte_sel) begin
            next_r.byte_sel = 1'b1;
            next_r.tx_bit   = r.tx_word[7];
          end else begin
            next_r.phase = POTIS_IGN;
          end
        end
      end else if (r.phase == POTIS_RDB) begin
        // shift out msb first, the upper byte first
        next_r.tx_bit = r.byte_sel ? r.tx_word[4'h7 - r.bit_cnt[2:0]]
                                   : r.tx_word[4'hf - {1'b0, r.bit_cnt[2:0]}];
      end
    end
    if (r.phase == POTIS_RDB && r.bit_cnt == 4'h0 && scl_fall && !start_seen) begin
      next_r.bit_cnt = 4'h0;
    end
    if (sys_rst) begin
      next_r                        = '0;
      next_r.phase                  = POTIS_IDLE;
      next_r.ctl                    = POTIS_RUN;
      next_r.scl_d                  = 1'b1;
      next_r.sda_d                  = 1'b1;
      next_r.tx_bit                 = 1'b1;
      next_r.wiper_setting_register = `POTIS_WIPER_RST;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // output flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      wiper_tap <= `POTIS_WIPER_RST;
      shutdown  <= 1'b0;
      nvm_value <= 8'h00;
      nvm_busy  <= 1'b0;
    end else begin
      // open drain: only ever pull low
      sda_oe    <= next_r.drive_low | (next_r.phase == POTIS_RDB && next_r.bit_cnt < 4'h8
                   && !next_r.tx_bit);
      sda_out   <= 1'b0;
      wiper_tap <= next_r.wiper_setting_register;
      shutdown  <= next_r.shut;
      nvm_value <= next_r.nvm;
      nvm_busy  <= (next_r.ctl == POTIS_STORE);
    end
  end
endmodule // potis_slave
`default_nettype wire

//--- rtl/potis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module potis_sync
  import potis_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // raw pin and its sampled form
  input  wire logic pin_in,
  output logic      pin_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } potis_sync_t;
  potis_sync_t r;
  potis_sync_t next_r;
  always_comb begin
    next_r      = r;
    next_r.meta = pin_in;
    next_r.sync = r.meta;
    if (sys_rst) begin
      next_r = '{meta: 1'b1, sync: 1'b1};
    end
  end
  always_ff @(posedge clk) begin
    r <= next_r;
  end
  assign pin_sync = r.sync;
endmodule // potis_sync
`default_nettype wire

//--- rtl/potis_timer.sv
`timescale 1ns/1ps
`default_nettype none
module potis_timer
  import potis_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // load a count, busy until it runs out
  input  wire logic        start,
  input  wire logic [19:0] count,
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic [19:0] left;
    logic        busy;
    logic        done;
  } potis_tmr_t;
  potis_tmr_t r;
  potis_tmr_t next_r;
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.left = count;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (r.left <= 20'h00001) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.left = r.left - 20'h00001;
      end
    end
    if (sys_rst) begin
      next_r = '0;
    end
  end
  always_ff @(posedge clk) begin
    r <= next_r;
  end
  assign busy = r.busy;
  assign done = r.done;
endmodule // potis_timer
`default_nettype wire
